// >>> design/tsseq_pkg.sv
// constants for the trigger step sequencer command decoder
package tsseq_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_ADJ = 8'h08;
    localparam logic [7:0] OFS_HOLD = 8'h0C;
    localparam logic [7:0] OFS_LIM_BASE = 8'h10;
    localparam logic [7:0] OFS_CNT0 = 8'h28;
    localparam logic [7:0] OFS_CNT1 = 8'h2C;
    localparam logic [7:0] OFS_ADCSEL = 8'h30;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
    localparam logic [7:0] OFS_QUEUE = 8'h40;
    localparam logic [7:0] OFS_QUEUE_END = 8'h5C;
    // control register bit positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    // limit array slots, also the add/copy target option codes
    localparam int LIM_COUNT = 6;
    localparam logic [2:0] LIM_TIMER0 = 3'h0;
    localparam logic [2:0] LIM_TIMER1 = 3'h1;
    localparam logic [2:0] LIM_STEP_DELAY = 3'h2;
    localparam logic [2:0] LIM_LOOP0 = 3'h3;
    localparam logic [2:0] LIM_LOOP1 = 3'h4;
    localparam logic [2:0] LIM_LITERAL0 = 3'h5;
    localparam logic [2:0] LIM_NONE = 3'h7;
    // command opcodes (upper nibble) and prefixes of paired opcodes
    localparam logic [3:0] OP_CTRL = 4'h0;
    localparam logic [3:0] OP_ADD_COPY = 4'h1;
    localparam logic [2:0] OP_STRB = 3'h1;
    localparam logic [3:0] OP_WAIT_RISE = 4'h4;
    localparam logic [3:0] OP_WAIT_FALL = 4'h5;
    localparam logic [3:0] OP_IRQ = 4'h7;
    localparam logic [2:0] OP_TRIG = 3'h4;
    localparam logic [2:0] OP_JMP = 3'h5;
    localparam logic [2:0] OP_JMPC0 = 3'h6;
    localparam logic [2:0] OP_JMPC1 = 3'h7;
    // control option that loads literal zero into the channel select
    localparam logic [3:0] CTRL_OPT_LIT0_TO_ADC = 4'h1;
    // bus responses and reset values
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [4:0] QPTR_RESET = 5'h00;
    typedef enum logic [1:0] {
        TSSEQ_IDLE,
        TSSEQ_EXEC,
        TSSEQ_WAIT
    } tsseq_state_t;
endpackage : tsseq_pkg

// >>> design/tsseq_decode.sv
// step command decoder and executor with its axi4-lite register file
// Overview of operation
// - opcode 0000 runs option-selected control operation
// - opcode 0001 adds adjust into option target
// - copy command moves hold into option target
// - 001x writes five-bit channel select field
// - 0100 stalls until selected input rises
// - 0101 stalls until selected input falls
// - reserved commands and options act as nop
// - 0111 raises option-selected interrupt request
// - 100x pulses five-bit selected trigger output
// - 101x loads pointer with five-bit target
// - 110x at limit: pointer just increments
// - 110x not at limit: count0 up, jump
// - 111x at limit: pointer just increments
// - 111x not at limit: count1 up, jump
// - adjust is 16-bit addend for limits, literal
// - control step copies literal zero to channel select
// - adjust, literal locked while enabled and started
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module tsseq_decode #(
    parameter int TRIG_IN_W = 16,
    parameter int TRIG_OUT_W = 32,
    parameter int IRQ_W = 16,
    parameter int QUEUE_DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [TRIG_IN_W-1:0] trig_in,
    output logic [TRIG_OUT_W-1:0] trig_out,
    output logic [IRQ_W-1:0] irq_out,
    output logic [15:0] adc_channel_select,
    output logic interrupt
);
    // limit-array slot for a bus address, none when not a limit
    function automatic logic [2:0] lim_slot(input logic [7:0] a);
        logic [7:0] d;
        d = a - tsseq_pkg::OFS_LIM_BASE;
        if (a >= tsseq_pkg::OFS_LIM_BASE && d[1:0] == 2'h0 &&
            d[7:2] < 6'(tsseq_pkg::LIM_COUNT))
            lim_slot = d[4:2];
        else
            lim_slot = tsseq_pkg::LIM_NONE;
    endfunction : lim_slot

    // merge a 32-bit write into a 16-bit register by byte lane
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    localparam logic [15:0] REG_ZERO = tsseq_pkg::REG16_RESET;
    tsseq_pkg::tsseq_state_t state_reg;
    logic [7:0] queue_mem [QUEUE_DEPTH];
    logic [4:0] queue_pointer;
    logic [15:0] lim_reg [tsseq_pkg::LIM_COUNT];
    logic [15:0] adjust_value, hold_value;
    logic [15:0] loop_counter0, loop_counter1;
    logic [15:0] irq_stat_reg, irq_mask_reg;
    logic sequencer_enable, sequencer_start;
    logic [TRIG_IN_W-1:0] trig_prev_reg;
    logic aw_hold_reg, w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic running, wr_fire, wr_locked, wr_map;
    logic [2:0] wr_slot;
    // decoded step effects
    logic [7:0] step_byte;
    logic [3:0] opc, opt;
    logic [4:0] target5;
    logic [4:0] qptr_next;
    logic lim_we, adc_full_we, adc_low_we, c0_inc, c1_inc, to_wait;
    logic [2:0] lim_idx;
    logic [15:0] lim_val;
    logic [TRIG_OUT_W-1:0] trig_next;
    logic [IRQ_W-1:0] irq_next;
    logic edge_seen;

    assign running = sequencer_enable & sequencer_start;
    assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    assign wr_slot = lim_slot(aw_addr_reg);
    assign wr_locked = running;
    assign step_byte = queue_mem[queue_pointer];
    assign opc = step_byte[7:4];
    assign opt = step_byte[3:0];
    assign target5 = {opc[0], opt};

    // decode the current step byte into its effects
    always_comb begin
        qptr_next = queue_pointer + 5'h01;
        lim_we = 1'b0;
        lim_idx = opt[2:0];
        lim_val = REG_ZERO;
        adc_full_we = 1'b0;
        adc_low_we = 1'b0;
        c0_inc = 1'b0;
        c1_inc = 1'b0;
        to_wait = 1'b0;
        trig_next = '0;
        irq_next = '0;
        if (opc == tsseq_pkg::OP_CTRL) begin
            if (opt == tsseq_pkg::CTRL_OPT_LIT0_TO_ADC)
                adc_full_we = 1'b1;
        end else if (opc == tsseq_pkg::OP_ADD_COPY) begin
            if (opt[2:0] < 3'(tsseq_pkg::LIM_COUNT)) begin
                lim_we = 1'b1;
                if (opt[3])
                    lim_val = hold_value;
                else
                    lim_val = lim_reg[opt[2:0]] + adjust_value;
            end
        end else if (opc[3:1] == tsseq_pkg::OP_STRB) begin
            adc_low_we = 1'b1;
        end else if (opc == tsseq_pkg::OP_WAIT_RISE ||
                     opc == tsseq_pkg::OP_WAIT_FALL) begin
            if (32'(opt) < TRIG_IN_W) begin
                to_wait = 1'b1;
                qptr_next = queue_pointer;
            end
        end else if (opc == tsseq_pkg::OP_IRQ) begin
            if (32'(opt) < IRQ_W)
                irq_next[opt] = 1'b1;
        end else if (opc[3:1] == tsseq_pkg::OP_TRIG) begin
            if (32'(target5) < TRIG_OUT_W)
                trig_next[target5] = 1'b1;
        end else if (opc[3:1] == tsseq_pkg::OP_JMP) begin
            qptr_next = target5;
        end else if (opc[3:1] == tsseq_pkg::OP_JMPC0) begin
            if (loop_counter0 != lim_reg[tsseq_pkg::LIM_LOOP0]) begin
                c0_inc = 1'b1;
                qptr_next = target5;
            end // else falls through
        end else if (opc[3:1] == tsseq_pkg::OP_JMPC1) begin
            if (loop_counter1 != lim_reg[tsseq_pkg::LIM_LOOP1]) begin
                c1_inc = 1'b1;
                qptr_next = target5;
            end // else falls through
        end
        // opcode 0110 and unlisted options change nothing
    end

    // edge seen on the input named by the waiting step
    always_comb begin
        edge_seen = 1'b0;
        if (32'(opt) < TRIG_IN_W) begin
            if (opc == tsseq_pkg::OP_WAIT_RISE)
                edge_seen = trig_in[opt] & ~trig_prev_reg[opt];
            else
                edge_seen = ~trig_in[opt] & trig_prev_reg[opt];
        end
    end

    // sequencer state and queue pointer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= tsseq_pkg::TSSEQ_IDLE;
            queue_pointer <= tsseq_pkg::QPTR_RESET;
        end else if (!running) begin
            state_reg <= tsseq_pkg::TSSEQ_IDLE;
            if (!sequencer_enable)
                queue_pointer <= tsseq_pkg::QPTR_RESET;
        end else begin
            case (state_reg)
                tsseq_pkg::TSSEQ_IDLE: begin
                    state_reg <= tsseq_pkg::TSSEQ_EXEC;
                end
                tsseq_pkg::TSSEQ_EXEC: begin
                    queue_pointer <= qptr_next;
                    if (to_wait)
                        state_reg <= tsseq_pkg::TSSEQ_WAIT;
                end
                tsseq_pkg::TSSEQ_WAIT: begin
                    if (edge_seen) begin
                        queue_pointer <= queue_pointer + 5'h01;
                        state_reg <= tsseq_pkg::TSSEQ_EXEC;
                    end
                end
                default: state_reg <= tsseq_pkg::TSSEQ_IDLE;
            endcase
        end
    end

    logic exec_now;
    assign exec_now = running && state_reg == tsseq_pkg::TSSEQ_EXEC;

    // trigger input history for edge detection
    always_ff @(posedge clock) begin
        if (rst)
            trig_prev_reg <= '0;
        else
            trig_prev_reg <= trig_in;
    end

    // trigger and interrupt request pulses
    always_ff @(posedge clock) begin
        if (rst) begin
            trig_out <= '0;
            irq_out <= '0;
        end else begin
            trig_out <= exec_now ? trig_next : '0;
            irq_out <= exec_now ? irq_next : '0;
        end
    end

    // channel select register
    always_ff @(posedge clock) begin
        if (rst)
            adc_channel_select <= REG_ZERO;
        else if (exec_now && adc_full_we)
            adc_channel_select <= lim_reg[tsseq_pkg::LIM_LITERAL0];
        else if (exec_now && adc_low_we)
            adc_channel_select[4:0] <= target5;
    end

    // loop counters, cleared while the sequencer is disabled
    always_ff @(posedge clock) begin
        if (rst || !sequencer_enable) begin
            loop_counter0 <= REG_ZERO;
            loop_counter1 <= REG_ZERO;
        end else begin
            if (exec_now && c0_inc)
                loop_counter0 <= loop_counter0 + 16'h0001;
            if (exec_now && c1_inc)
                loop_counter1 <= loop_counter1 + 16'h0001;
        end
    end

    // limit and literal array: software writes or step add/copy
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < tsseq_pkg::LIM_COUNT; i++)
                lim_reg[i] <= REG_ZERO;
        end else if (exec_now && lim_we) begin
            lim_reg[lim_idx] <= lim_val;
        end else if (wr_fire && !wr_locked &&
                     wr_slot != tsseq_pkg::LIM_NONE) begin
            lim_reg[wr_slot] <= merge16(lim_reg[wr_slot], w_data_reg,
                                        w_strb_reg);
        end
    end

    // control, adjust, hold and mask registers
    always_ff @(posedge clock) begin
        if (rst) begin
            sequencer_enable <= 1'b0;
            sequencer_start <= 1'b0;
            adjust_value <= REG_ZERO;
            hold_value <= REG_ZERO;
            irq_mask_reg <= REG_ZERO;
        end else if (wr_fire) begin
            case (aw_addr_reg)
                tsseq_pkg::OFS_CTRL: begin
                    if (w_strb_reg[0]) begin
                        sequencer_enable <= w_data_reg[tsseq_pkg::CTRL_EN_BIT];
                        sequencer_start <=
                            w_data_reg[tsseq_pkg::CTRL_START_BIT];
                    end
                end
                tsseq_pkg::OFS_ADJ: begin
                    if (!wr_locked)
                        adjust_value <= merge16(adjust_value, w_data_reg,
                                                w_strb_reg);
                end
                tsseq_pkg::OFS_HOLD:
                    hold_value <= merge16(hold_value, w_data_reg, w_strb_reg);
                tsseq_pkg::OFS_IRQ_MASK:
                    irq_mask_reg <= merge16(irq_mask_reg, w_data_reg,
                                            w_strb_reg);
                default: ;
            endcase
        end
    end

    // sticky interrupt status, write one to clear, set wins
    logic [15:0] irq_clr;
    assign irq_clr = (wr_fire && aw_addr_reg == tsseq_pkg::OFS_IRQ_STAT) ?
                     merge16(REG_ZERO, w_data_reg, w_strb_reg) : REG_ZERO;
    always_ff @(posedge clock) begin
        if (rst)
            irq_stat_reg <= REG_ZERO;
        else
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) |
                            (exec_now ? 16'(irq_next) : REG_ZERO);
    end

    // level interrupt from unmasked status bits
    always_ff @(posedge clock) begin
        if (rst)
            interrupt <= 1'b0;
        else
            interrupt <= |(irq_stat_reg & irq_mask_reg);
    end

    // step queue storage, byte-lane writes of four steps a word
    always_ff @(posedge clock) begin
        if (wr_fire && aw_addr_reg >= tsseq_pkg::OFS_QUEUE &&
            aw_addr_reg <= tsseq_pkg::OFS_QUEUE_END &&
            aw_addr_reg[1:0] == 2'h0) begin
            for (int b = 0; b < 4; b++)
                if (w_strb_reg[b])
                    queue_mem[{aw_addr_reg[4:2], 2'(b)}] <= w_data_reg[8*b +: 8];
        end
    end

    // write mapping check
    always_comb begin
        case (aw_addr_reg)
            tsseq_pkg::OFS_CTRL, tsseq_pkg::OFS_ADJ, tsseq_pkg::OFS_HOLD,
            tsseq_pkg::OFS_IRQ_STAT, tsseq_pkg::OFS_IRQ_MASK:
                wr_map = 1'b1;
            default:
                wr_map = wr_slot != tsseq_pkg::LIM_NONE ||
                         (aw_addr_reg >= tsseq_pkg::OFS_QUEUE &&
                          aw_addr_reg <= tsseq_pkg::OFS_QUEUE_END &&
                          aw_addr_reg[1:0] == 2'h0);
        endcase
    end

    // axi write channels: address and data in either order
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tsseq_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? tsseq_pkg::RESP_OKAY
                                      : tsseq_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read data mux
    logic [31:0] rd_val;
    logic rd_map;
    logic [2:0] rd_slot;
    logic [7:0] qa;
    assign rd_slot = lim_slot(s_axi_araddr);
    always_comb begin
        rd_map = 1'b1;
        rd_val = 32'h0000_0000;
        qa = {3'h0, s_axi_araddr[4:2], 2'h0};
        case (s_axi_araddr)
            tsseq_pkg::OFS_CTRL:
                rd_val[1:0] = {sequencer_start, sequencer_enable};
            tsseq_pkg::OFS_STAT:
                rd_val[9:0] = {state_reg == tsseq_pkg::TSSEQ_WAIT,
                               state_reg != tsseq_pkg::TSSEQ_IDLE,
                               3'h0, queue_pointer};
            tsseq_pkg::OFS_ADJ: rd_val[15:0] = adjust_value;
            tsseq_pkg::OFS_HOLD: rd_val[15:0] = hold_value;
            tsseq_pkg::OFS_CNT0: rd_val[15:0] = loop_counter0;
            tsseq_pkg::OFS_CNT1: rd_val[15:0] = loop_counter1;
            tsseq_pkg::OFS_ADCSEL: rd_val[15:0] = adc_channel_select;
            tsseq_pkg::OFS_IRQ_STAT: rd_val[15:0] = irq_stat_reg;
            tsseq_pkg::OFS_IRQ_MASK: rd_val[15:0] = irq_mask_reg;
            default: begin
                if (rd_slot != tsseq_pkg::LIM_NONE)
                    rd_val[15:0] = lim_reg[rd_slot];
                else if (s_axi_araddr >= tsseq_pkg::OFS_QUEUE &&
                         s_axi_araddr <= tsseq_pkg::OFS_QUEUE_END &&
                         s_axi_araddr[1:0] == 2'h0)
                    rd_val = {queue_mem[5'(qa) + 5'h03],
                              queue_mem[5'(qa) + 5'h02],
                              queue_mem[5'(qa) + 5'h01], queue_mem[5'(qa)]};
                else
                    rd_map = 1'b0;
            end
        endcase
    end

    // axi read channel, one cycle answer
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tsseq_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_map ? tsseq_pkg::RESP_OKAY
                                  : tsseq_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule : tsseq_decode

// >>> bench/tsseq_decode_chk.sv
// assertion checker for the sequencer bus handshakes and pulse outputs
`timescale 1ns/1ps
module tsseq_decode_chk #(
    parameter int TRIG_OUT_W = 32,
    parameter int IRQ_W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [TRIG_OUT_W-1:0] trig_out,
    input wire logic [IRQ_W-1:0] irq_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // bus answers, holds and refusals
    AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    AST_AW_BLOCK: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read response missing");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    // one step per clock means at most one pulse per clock
    AST_TRIG_ONE: assert property ($onehot0(trig_out))
        else $error("several trigger outputs at once");
    AST_IRQ_ONE: assert property ($onehot0(irq_out))
        else $error("several interrupt requests at once");
    AST_RESET: assert property (disable iff (1'b0) rst |=>
        s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid
        && trig_out == '0 && irq_out == '0) else $error("bad reset state");
endmodule : tsseq_decode_chk

bind tsseq_decode tsseq_decode_chk #(.TRIG_OUT_W(TRIG_OUT_W), .IRQ_W(IRQ_W))
    u_chk (.clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .trig_out(trig_out), .irq_out(irq_out));

// >>> bench/tsseq_periph_model.sv
// behavioural model of the peripherals around the sequencer
`timescale 1ns/1ps
module tsseq_periph_model #(
    parameter int TRIG_IN_W = 16,
    parameter int TRIG_OUT_W = 32,
    parameter int IRQ_W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [TRIG_IN_W-1:0] level,
    output logic [TRIG_IN_W-1:0] trig_in,
    input wire logic [TRIG_OUT_W-1:0] trig_out,
    input wire logic [IRQ_W-1:0] irq_out,
    output int trig_cnt [TRIG_OUT_W],
    output int irq_cnt [IRQ_W]
);
    // trigger sources move just after the edge, like a clocked peripheral
    always @(posedge clock) trig_in <= rst ? '0 : level;
    // count each one-cycle pulse per line
    always @(posedge clock) begin
        for (int i = 0; i < TRIG_OUT_W; i++) begin
            trig_cnt[i] <= rst ? 0 : trig_cnt[i] + (trig_out[i] === 1'b1);
        end
        for (int i = 0; i < IRQ_W; i++) begin
            irq_cnt[i] <= rst ? 0 : irq_cnt[i] + (irq_out[i] === 1'b1);
        end
    end
endmodule : tsseq_periph_model

// >>> bench/tb.sv
// self-checking bench for the step sequencer decoder
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) \
    begin fail_count++; $display("FAIL %0t %s", $time, msg); end end
module tb;
    logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, interrupt;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] level, trig_in, irq_out, adc_sel;
    logic [31:0] trig_out;
    int trig_cnt [32];
    int irq_cnt [16];
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    tsseq_decode i_dut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .trig_in(trig_in), .trig_out(trig_out),
        .irq_out(irq_out), .adc_channel_select(adc_sel),
        .interrupt(interrupt));
    tsseq_periph_model i_periph (.clock(clock), .rst(rst), .level(level),
        .trig_in(trig_in), .trig_out(trig_out), .irq_out(irq_out),
        .trig_cnt(trig_cnt), .irq_cnt(irq_cnt));
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!bvalid);
        bready <= 1'b1;
        @(posedge clock);
        resp = bresp;
    endtask : wr
    // bus read
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b0;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        rready <= 1'b1;
        @(posedge clock);
        rd = rdata;
        resp = rresp;
    endtask : rdr
    // main sequence
    initial begin
        rst <= 1'b1;
        {awvalid, wvalid, arvalid, awaddr, araddr, wdata} <= '0;
        bready <= 1'b1;
        rready <= 1'b1;
        level <= 16'h0002;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        wr(tsseq_pkg::OFS_ADJ, 32'h1);
        wr(8'h1C, 32'h1);
        wr(8'h20, 32'h1);
        wr(8'h24, 32'h1234);
        wr(8'h40, 32'h603F1301);
        wr(8'h44, 32'h51409572);
        wr(8'h48, 32'hADEAC881);
        wr(8'h4C, 32'h00AE7380);
        wr(tsseq_pkg::OFS_CTRL, 32'h3);
        repeat (20) @(posedge clock);
        rdr(tsseq_pkg::OFS_STAT);
        `CHK(rd & 32'h21F, 32'h206, "no stall on rise wait")
        wr(tsseq_pkg::OFS_ADJ, 32'h55);
        `CHK(resp, tsseq_pkg::RESP_OKAY, "locked write answer")
        rdr(tsseq_pkg::OFS_ADJ);
        `CHK(rd, 32'h1, "adjust written while running")
        level <= 16'h0003;
        repeat (10) @(posedge clock);
        rdr(tsseq_pkg::OFS_STAT);
        `CHK(rd & 32'h21F, 32'h207, "rise not taken")
        level <= 16'h0001;
        repeat (40) @(posedge clock);
        $display("test run program done");
        rdr(tsseq_pkg::OFS_STAT);
        `CHK(rd & 32'h1F, 32'hE, "pointer wrong")
        `CHK(adc_sel, 16'h123F, "channel select")
        rdr(8'h1C);
        `CHK(rd, 32'h2, "add into loop limit")
        rdr(tsseq_pkg::OFS_CNT0);
        `CHK(rd, 32'h2, "loop counter zero")
        rdr(tsseq_pkg::OFS_CNT1);
        `CHK(rd, 32'h1, "loop counter one")
        `CHK(trig_cnt[1], 3, "loop body pulses")
        `CHK(trig_cnt[21], 1, "trigger output 21")
        `CHK(trig_cnt[0], 0, "skipped step ran")
        `CHK(irq_cnt[2], 1, "irq 2 pulse")
        `CHK(irq_cnt[3], 1, "irq 3 pulse")
        $display("test pulses done");
        rdr(tsseq_pkg::OFS_IRQ_STAT);
        `CHK(rd, 32'hC, "irq status")
        `CHK(interrupt, 1'b0, "interrupt while masked")
        wr(tsseq_pkg::OFS_IRQ_MASK, 32'h4);
        rdr(tsseq_pkg::OFS_IRQ_MASK);
        `CHK(interrupt, 1'b1, "interrupt not raised")
        wr(tsseq_pkg::OFS_IRQ_STAT, 32'h4);
        rdr(tsseq_pkg::OFS_IRQ_STAT);
        `CHK(rd, 32'h8, "status clear")
        `CHK(interrupt, 1'b0, "interrupt not cleared")
        wr(tsseq_pkg::OFS_CTRL, 32'h0);
        wr(tsseq_pkg::OFS_ADJ, 32'h55);
        rdr(tsseq_pkg::OFS_ADJ);
        `CHK(rd, 32'h55, "adjust locked when stopped")
        wr(8'h3C, 32'h1);
        `CHK(resp, tsseq_pkg::RESP_SLVERR, "unmapped write")
        rdr(8'h3C);
        `CHK(resp, tsseq_pkg::RESP_SLVERR, "unmapped read")
        $display("test registers done");
        complete_run();
    end
endmodule : tb
